// File: hw/rsh_alu.sv
// rotate and literal-minus-accumulator datapath
`timescale 1ns/1ps
module rsh_alu (
  rsh_exec_if.alu ex
);
  import rsh_pkg::*;
  logic [8:0] diff9; // nine bits keep the borrow
  logic [4:0] nib5;  // low nibble with its borrow
  // purely combinational; the core samples it in q3
  always_comb begin
    diff9     = {1'b0, ex.operand} - {1'b0, ex.acc}; // RULE11
    nib5      = {1'b0, ex.operand[3:0]} - {1'b0, ex.acc[3:0]};
    ex.result = 8'h00;
    ex.c_out  = ex.c_in;
    ex.dc_out = 1'b0;
    ex.z_out  = 1'b0;
    case (ex.kind)
      K_RL: begin
        ex.result = {ex.operand[6:0], ex.c_in}; // RULE1
        ex.c_out  = ex.operand[7]; // RULE1
      end
      K_RR: begin
        ex.result = {ex.c_in, ex.operand[7:1]}; // RULE2
        ex.c_out  = ex.operand[0]; // RULE2
      end
      K_SUB: begin
        ex.result = diff9[7:0];
        ex.c_out  = ~diff9[8]; // RULE14 RULE15
        ex.dc_out = ~nib5[4]; // RULE16
        ex.z_out  = (diff9[7:0] == 8'h00); // RULE15
      end
      default: begin
        ex.result = 8'h00; // no-op and halt use no result
      end
    endcase
  end
endmodule

// File: hw/rsh_exec.sv
// execution core for rotate, subtract and halt behind an apb slave
`timescale 1ns/1ps
module rsh_exec (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             halted
);
  import rsh_pkg::*;

  rsh_exec_if ex (); // link to sequencer and alu

  // apb state
  // the answer is registered: one setup, one access, no wait states
  logic [31:0] prdata_q;   // read data, loaded in setup
  logic        pready_q;   // one access cycle per transfer
  logic        pslverr_q;  // error for this transfer
  logic [31:0] rd_data;    // read mux
  logic        rd_err;     // unmapped or refused
  logic        setup_ph;   // setup cycle seen
  logic        access_end; // completing edge
  logic        wr_en;      // accepted write
  // architectural state
  // carry, powerdown and expiry have a process each; nibble and zero share one, so each bit has one writer
  logic [7:0]  acc_q;      // accumulator
  logic        carry_q;    // carry flag
  logic        dc_q;       // nibble rollover bit
  logic        zero_q;     // zero flag
  logic        pwrdn_n_q;  // powerdown flag, low after halt
  logic        expiry_n_q; // expiry status, low after time-out
  logic        halted_q;   // halt mode
  logic        busy_q;     // instruction in flight
  logic [13:0] opcode_q;   // latched opcode
  rsh_kind_type kind_q;    // decoded in q1
  logic [7:0]  operand_q;  // read in q2
  logic [7:0]  res_q;      // processed in q3
  logic        c_res_q;    // carry from q3
  logic        dc_res_q;   // nibble bit from q3
  logic        z_res_q;    // zero from q3
  logic [6:0]  faddr_q;    // software file pointer
  logic [7:0]  wd_pre_q;   // watchdog prescaler
  logic [7:0]  wd_cnt_q;   // watchdog counter
  logic [7:0]  file_mem [128]; // file registers
  // phase strobes
  logic        in_q1;      // decode
  logic        in_q2;      // read
  logic        in_q3;      // process
  logic        in_q4;      // write
  logic        start;      // accepted instruction write
  logic        wd_ovf;     // watchdog wraps this cycle
  logic        halt_now;   // halt takes effect
  logic        rot_now;    // rotate writes back
  logic        sub_now;    // subtract writes back
  logic        file_dest;  // rotate targets the file

  // rotates share the file read and the carry-only write-back
  function automatic logic is_rotate(input rsh_kind_type k);
    return (k == K_RL) || (k == K_RR);
  endfunction

  // quarter-phase sequencer
  // the sequencer owns the phase; the core only reads it
  rsh_phase u_phase (
    .pclk    (pclk),
    .presetn (presetn),
    .ex      (ex.seq)
  );

  // rotate / subtract datapath
  rsh_alu u_alu (
    .ex (ex.alu)
  );

  // feed the carrier
  // the alu sees live accumulator and carry; the core samples in q3
  assign ex.ce      = ce;
  assign ex.start   = start;
  assign ex.kind    = kind_q;
  assign ex.operand = operand_q;
  assign ex.acc     = acc_q;
  assign ex.c_in    = carry_q;

  // phase decode
  // each strobe lasts one enabled pclk; ce low stretches it
  assign in_q1 = (ex.phase == PH_Q1);
  assign in_q2 = (ex.phase == PH_Q2);
  assign in_q3 = (ex.phase == PH_Q3);
  assign in_q4 = (ex.phase == PH_Q4);

  // write-back qualifiers
  // q4 strobes; the kind is settled from q2 on
  assign halt_now  = in_q4 && (kind_q == K_HALT); // RULE10
  assign rot_now   = in_q4 && is_rotate(kind_q);
  assign sub_now   = in_q4 && (kind_q == K_SUB);
  // bit 7 of the latched word; the subtract ignores it
  assign file_dest = opcode_q[7]; // RULE3

  // apb handshake terms
  assign setup_ph   = psel && !penable;
  assign access_end = psel && penable && pready_q;
  assign wr_en      = access_end && pwrite && !pslverr_q;
  // instructions are refused while busy or halted
  assign start = wr_en && (paddr == OFS_INSTR); // RULE9

  // read mux and error decode, sampled in setup
  // unaligned and out-of-range offsets fall to the default branch
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err  = 1'b0;
    case (paddr)
      OFS_INSTR: begin
        rd_data = {18'h0, opcode_q};
        rd_err  = pwrite && (busy_q || halted_q); // RULE9
      end
      OFS_ACC: rd_data = {24'h000000, acc_q};
      OFS_STATUS: begin
        rd_data[ST_C]  = carry_q;
        rd_data[ST_DC] = dc_q;
        rd_data[ST_Z]  = zero_q;
        rd_data[ST_PWRDN]  = pwrdn_n_q; // read-only
        rd_data[ST_EXPIRY] = expiry_n_q; // read-only
      end
      OFS_FADDR: rd_data = {25'h0, faddr_q};
      OFS_FDATA: rd_data = {24'h000000, file_mem[faddr_q]};
      OFS_WDOG:  rd_data = {16'h0000, wd_cnt_q, wd_pre_q};
      OFS_STATE: rd_data = {29'h0, ex.phase != PH_IDLE,
                            halted_q, busy_q};
      OFS_CTRL: rd_data = 32'h0000_0000; // write-only wake
      default: rd_err = 1'b1; // unmapped address
    endcase
  end

  // apb answer: ready in the first access cycle
  // limitation: ce low in an access cycle freezes pready high, so the
  // master completes while the write is dropped; keep ce high across
  // a transfer
  // pslverr and prdata only mean something while pready is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else if (ce) begin
      pready_q <= setup_ph;
      if (setup_ph) begin
        pslverr_q <= rd_err;
        // reads of write-only or errored words return zero
        prdata_q  <= (pwrite || rd_err) ? 32'h0000_0000 : rd_data;
      end
    end
  end

  // opcode latch and busy tracking
  // busy spans q1..q4; a word set up in that time is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcode_q <= OPC_RST;
      busy_q   <= 1'b0;
    end else if (ce) begin
      if (start) begin
        opcode_q <= pwdata[13:0];
        busy_q   <= 1'b1;
      end else if (in_q4) begin
        busy_q <= 1'b0; // one instruction cycle per word
      end
    end
  end

  // q1 decode, q2 read, q3 process
  // each stage holds its value, so q4 writes one settled result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_q    <= K_NOP;
      operand_q <= 8'h00;
      res_q     <= 8'h00;
      c_res_q   <= 1'b0;
      dc_res_q  <= 1'b0;
      z_res_q   <= 1'b0;
    end else if (ce) begin
      if (in_q1) begin
        kind_q <= rsh_decode(opcode_q); // RULE4 RULE13
      end
      if (in_q2) begin
        // halt leaves q2 idle; q3 still captures the alu defaults
        if (is_rotate(kind_q)) begin
          operand_q <= file_mem[opcode_q[6:0]]; // RULE3 RULE4
        end else if (kind_q == K_SUB) begin
          operand_q <= opcode_q[7:0]; // RULE13
        end
      end
      // capture here keeps the alu path out of the q4 write
      if (in_q3) begin
        res_q    <= ex.result; // RULE4
        c_res_q  <= ex.c_out;
        dc_res_q <= ex.dc_out;
        z_res_q  <= ex.z_out;
      end
    end
  end

  // accumulator: q4 write-back beats a software write
  // a software write in that same cycle is dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= ACC_RST;
    end else if (ce) begin
      if (sub_now) begin
        acc_q <= res_q; // RULE12
      end else if (rot_now && !file_dest) begin
        acc_q <= res_q; // RULE3
      end else if (wr_en && paddr == OFS_ACC) begin
        acc_q <= pwdata[7:0];
      end
    end
  end

  // file registers: rotate destination or software window
  // no reset: software fills a byte before reading it back
  always_ff @(posedge pclk) begin
    if (ce) begin
      if (rot_now && file_dest) begin
        file_mem[opcode_q[6:0]] <= res_q; // RULE3
      end else if (wr_en && paddr == OFS_FDATA) begin
        file_mem[faddr_q] <= pwdata[7:0];
      end
    end
  end

  // software file pointer
  // seven bits, so every offset written lands inside the file
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      faddr_q <= FADDR_RST;
    end else if (ce && wr_en && paddr == OFS_FADDR) begin
      faddr_q <= pwdata[6:0];
    end
  end

  // carry: both rotates and subtract, hardware first
  // rotates use carry as it stood in q3; a status write in q4 is lost
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      carry_q <= 1'b0;
    end else if (ce) begin
      if (rot_now || sub_now) begin
        carry_q <= c_res_q; // RULE1 RULE2 RULE14 RULE15
      end else if (wr_en && paddr == OFS_STATUS) begin
        carry_q <= pwdata[ST_C];
      end
    end
  end

  // nibble and zero: subtract only, rotates leave them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dc_q   <= 1'b0;
      zero_q <= 1'b0;
    end else if (ce) begin
      if (sub_now) begin
        dc_q   <= dc_res_q; // RULE16
        zero_q <= z_res_q; // RULE15
      end else if (wr_en && paddr == OFS_STATUS && !rot_now) begin
        // a status write during a rotate's q4 is dropped whole, as its
        // carry part is, so software never sees half a write
        dc_q   <= pwdata[ST_DC]; // RULE5
        zero_q <= pwdata[ST_Z];
      end
    end
  end

  // powerdown flag: only reset sets it again
  // so software still sees a past halt after the wake write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwrdn_n_q <= 1'b1;
    end else if (ce && halt_now) begin
      pwrdn_n_q <= 1'b0; // RULE6
    end
  end

  // expiry status: halt sets it, watchdog wrap clears it
  // a halt in the wrap cycle wins; software cannot write the bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      expiry_n_q <= 1'b1;
    end else if (ce) begin
      if (halt_now) begin
        expiry_n_q <= 1'b1; // RULE7
      end else if (wd_ovf) begin
        expiry_n_q <= 1'b0;
      end
    end
  end

  // watchdog wraps when both stages are at the top
  // a wrap clears the expiry bit unless a halt lands in that cycle
  assign wd_ovf = (wd_pre_q == WD_TOP) && (wd_cnt_q == WD_TOP);

  // watchdog prescaler and counter, free running
  // it keeps running in halt: this block has no oscillator to stop
  // the counter steps once every 256 prescaler counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_pre_q <= WD_CLEAR;
      wd_cnt_q <= WD_CLEAR;
    end else if (ce) begin
      if (halt_now) begin
        wd_pre_q <= WD_CLEAR; // RULE8
        wd_cnt_q <= WD_CLEAR; // RULE8
      end else begin
        wd_pre_q <= wd_pre_q + 8'h01;
        if (wd_pre_q == WD_TOP) begin
          wd_cnt_q <= wd_cnt_q + 8'h01;
        end
      end
    end
  end

  // halt mode: entered in q4, left by a wake write
  // only software wakes the core; other wake sources lie outside
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halted_q <= 1'b0;
    end else if (ce) begin
      if (halt_now) begin
        halted_q <= 1'b1; // RULE9 RULE10
      end else if (wr_en && paddr == OFS_CTRL && pwdata[0]) begin
        halted_q <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  // halted repeats the state register bit for a system-level hook
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign halted  = halted_q;
endmodule

// File: hw/rsh_phase.sv
// quarter-phase sequencer: one enabled pclk cycle per phase
`timescale 1ns/1ps
module rsh_phase (
  input wire logic pclk,
  input wire logic presetn,
  rsh_exec_if.seq  ex
);
  import rsh_pkg::*;
  rsh_phase_type phase_q; // current phase
  rsh_phase_type phase_d; // next phase
  // walk q1..q4 once per start
  always_comb begin
    case (phase_q)
      PH_IDLE: phase_d = ex.start ? PH_Q1 : PH_IDLE;
      PH_Q1:   phase_d = PH_Q2; // RULE4
      PH_Q2:   phase_d = PH_Q3;
      PH_Q3:   phase_d = PH_Q4;
      PH_Q4:   phase_d = PH_IDLE; // RULE13
      default: phase_d = PH_IDLE;
    endcase
  end
  // phase register, frozen by ce
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= PH_IDLE;
    end else if (ex.ce) begin
      phase_q <= phase_d;
    end
  end
  assign ex.phase = phase_q;
endmodule

// File: shared/rsh_exec_if.sv
// carrier between the core, the phase sequencer and the alu
`timescale 1ns/1ps
interface rsh_exec_if;
  import rsh_pkg::*;
  logic          ce;      // clock enable
  logic          start;   // one-cycle start of an instruction
  rsh_phase_type phase;   // current quarter phase
  rsh_kind_type  kind;    // decoded instruction
  logic [7:0]    operand; // file byte or literal
  logic [7:0]    acc;     // accumulator value
  logic          c_in;    // carry before the instruction
  logic [7:0]    result;  // alu result
  logic          c_out;   // new carry
  logic          dc_out;  // new nibble rollover
  logic          z_out;   // subtract result is zero
  modport seq (input ce, input start, output phase);
  modport alu (input kind, input operand, input acc, input c_in,
               output result, output c_out, output dc_out,
               output z_out);
  modport core (output ce, output start, output kind, output operand,
                output acc, output c_in, input phase, input result,
                input c_out, input dc_out, input z_out);
endinterface

// File: shared/rsh_pkg.sv
// constants, types and decode helper for the rotate/subtract/halt block
// Operation
// RULE1 - rotate left: old carry in, bit7 out
// RULE2 - rotate right: old carry in, bit0 out
// RULE3 - rotates: 7-bit address, destination bit selects
// RULE4 - rotates: decode, read, process, write phases
// RULE5 - rotates change only the carry flag
// RULE6 - halt clears powerdown flag
// RULE7 - halt sets expiry status bit
// RULE8 - halt clears watchdog counter and prescaler
// RULE9 - halted core executes nothing until woken
// RULE10 - halt opcode fixed, enters halt in phase four
// RULE11 - subtract: literal minus accumulator, two's complement
// RULE12 - subtract result always goes to accumulator
// RULE13 - subtract: decode, read literal, process, write
// RULE14 - subtract: carry set when no borrow
// RULE15 - borrow clears carry; zero flag on zero
// RULE16 - nibble bit set when no low-nibble borrow
package rsh_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_INSTR  = 8'h00;
  localparam logic [7:0] OFS_ACC    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FADDR  = 8'h0C;
  localparam logic [7:0] OFS_FDATA  = 8'h10;
  localparam logic [7:0] OFS_WDOG   = 8'h14;
  localparam logic [7:0] OFS_STATE  = 8'h18;
  localparam logic [7:0] OFS_CTRL   = 8'h1C;
  // status field positions
  localparam int ST_C      = 0;
  localparam int ST_DC     = 1;
  localparam int ST_Z      = 2;
  localparam int ST_PWRDN  = 3;
  localparam int ST_EXPIRY = 4;
  // reset and clear values
  localparam logic [7:0]  ACC_RST   = 8'h00;
  localparam logic [6:0]  FADDR_RST = 7'h00;
  localparam logic [7:0]  WD_CLEAR  = 8'h00;
  localparam logic [7:0]  WD_TOP    = 8'hFF;
  localparam logic [13:0] OPC_RST   = 14'h0000;
  // opcode patterns
  localparam logic [5:0]  OPC_ROT_LEFT  = 6'h0D;
  localparam logic [5:0]  OPC_ROT_RIGHT = 6'h0C;
  localparam logic [4:0]  OPC_SUB_LIT   = 5'h1E;
  localparam logic [13:0] OPC_HALT      = 14'h0063;
  // decoded instruction kind
  typedef enum logic [2:0] {
    K_NOP, K_RL, K_RR, K_SUB, K_HALT
  } rsh_kind_type;
  // quarter phases, gray coded from idle to q4; the step from q4 back to idle flips two bits
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000, PH_Q1 = 3'b001, PH_Q2 = 3'b011,
    PH_Q3 = 3'b010, PH_Q4 = 3'b110
  } rsh_phase_type;
  // opcode to kind; unknown words decode as no-op
  function automatic rsh_kind_type rsh_decode(input logic [13:0] op);
    if (op[13:8] == OPC_ROT_LEFT) return K_RL; // RULE1
    if (op[13:8] == OPC_ROT_RIGHT) return K_RR; // RULE2
    if (op[13:9] == OPC_SUB_LIT) return K_SUB; // RULE11
    if (op == OPC_HALT) return K_HALT; // RULE10
    return K_NOP;
  endfunction
endpackage

// File: tb/rsh_exec_properties.sv
// assertions on the apb ports of the execution core
`timescale 1ns/1ps
module rsh_exec_properties
  import rsh_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        ce,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        halted
);
  logic setup; // setup edge seen by the slave
  logic acc_w; // completed write
  logic halt_go; // accepted halt word
  logic wake; // accepted wake request
  assign setup = psel && !penable && ce;
  assign acc_w = psel && penable && pready && pwrite && ce;
  assign halt_go = acc_w && paddr == OFS_INSTR && !pslverr
                   && pwdata[13:0] == OPC_HALT;
  assign wake = acc_w && paddr == OFS_CTRL && pwdata[0];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // zero wait states, one-cycle answer
  pready_next_a: assert property (setup |=> pready)
    else $error("no answer after setup");
  pready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("answer held too long");
  pready_quiet_a: assert property (!psel && ce |=> !pready)
    else $error("answer without request");
  unmapped_err_a: assert property (setup && paddr > OFS_CTRL
    |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // halt lands in the fourth phase after the opcode edge
  halt_entry_a: assert property (halt_go |=> !halted[*4] ##1 halted)
    else $error("halt entry timing wrong");
  halt_hold_a: assert property (halted && !wake |=> halted)
    else $error("halt left without wake");
  halt_refuse_a: assert property (setup && pwrite && halted
    && paddr == OFS_INSTR |=> pslverr)
    else $error("instruction accepted while halted");
  halt_flags_a: assert property (setup && !pwrite && halted
    && paddr == OFS_STATUS
    |=> !prdata[ST_PWRDN] && prdata[ST_EXPIRY])
    else $error("halt status bits wrong");
  wake_a: assert property (halted && wake |=> !halted)
    else $error("wake ignored");
  halt_c: cover property (halt_go);
  wake_c: cover property (halted && wake);
  unmapped_c: cover property (setup && paddr > OFS_CTRL);
endmodule
bind rsh_exec rsh_exec_properties i_rsh_exec_properties (
  .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .halted(halted));

// File: tb/rsh_exec_tb_top.sv
// self-checking bench for the rotate, subtract and halt core
`timescale 1ns/1ps
module rsh_exec_tb_top;
  import rsh_pkg::*;
  logic        pclk = 1'b0;    // core clock
  logic        presetn = 1'b0; // reset, active low
  logic        ce = 1'b1;      // clock enable
  logic        psel = 1'b0;    // apb select
  logic        penable = 1'b0; // apb enable
  logic        pwrite = 1'b0;  // apb direction
  logic [7:0]  paddr = 8'h00;  // apb address
  logic [31:0] pwdata = 32'h0; // apb write data
  logic [31:0] prdata;         // apb read data
  logic        pready;         // apb answer
  logic        pslverr;        // apb error
  logic        halted;         // halt mode
  int          fail_count = 0; // mismatches
  int          n_compared = 0; // comparisons
  int unsigned seed = 18;      // xorshift state
  int          acc, cy, dc, zr; // reference accumulator and flags
  int          mem [128];      // reference file bytes
  int          f, t, x;        // scratch
  logic [13:0] op;             // opcode under test
  logic [31:0] rd;             // last read data
  logic        er;             // last error flag
  always #2 pclk = ~pclk;
  rsh_exec i_rsh_exec (.pclk(pclk), .presetn(presetn), .ce(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halted(halted));
  function automatic int unsigned rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // one apb transfer; an idle cycle follows so psel never double-drives
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) fail_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // start an instruction and poll until the core is idle again
  task automatic run(input logic [13:0] o);
    int n;
    n = 0;
    wr(OFS_INSTR, {18'h0, o});
    chk(er, 1'b0);
    do begin
      rdr(OFS_STATE);
      n++;
    end while (rd[0] !== 1'b0 && n < 20);
    if (n >= 20) fail_count++;
  endtask
  // reference model, integers only
  task automatic model(input logic [13:0] o);
    int v, k, r;
    v = mem[o[6:0]];
    k = o[7:0];
    r = -1;
    if (o[13:8] == OPC_ROT_LEFT) begin
      r = ((v << 1) | cy) & 255;
      cy = v >> 7;
    end else if (o[13:8] == OPC_ROT_RIGHT) begin
      r = (v >> 1) | (cy << 7);
      cy = v & 1;
    end else if (o[13:9] == OPC_SUB_LIT) begin
      sub_model(k);
    end
    if (r >= 0 && o[7]) mem[o[6:0]] = r;
    else if (r >= 0) acc = r;
  endtask
  task automatic sub_model(input int k);
    cy = (k >= acc);
    dc = ((k & 15) >= (acc & 15));
    acc = (k - acc) & 255;
    zr = (acc == 0);
  endtask
  task automatic check_all(input int a);
    wr(OFS_FADDR, a);
    rdr(OFS_FDATA);
    chk(rd, mem[a]);
    rdr(OFS_ACC);
    chk(rd, acc);
    rdr(OFS_STATUS);
    chk(rd[4:0], {2'b11, zr[0], dc[0], cy[0]});
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdr(OFS_STATUS);
    chk(rd, 32'h18);
    rdr(8'h20);
    chk(er, 1'b1);
    // random operands through both rotates, subtract and no-op, carry and borrow both ways
    for (int i = 0; i < 40; i++) begin
      f = rnd() % 128;
      mem[f] = rnd() & 255;
      wr(OFS_FADDR, f);
      wr(OFS_FDATA, mem[f]);
      acc = rnd() & 255;
      wr(OFS_ACC, acc);
      t = rnd() & 7;
      {zr, dc, cy} = {t >> 2, (t >> 1) & 1, t & 1};
      wr(OFS_STATUS, t);
      x = rnd();
      case (i % 4)
        0: op = {OPC_ROT_LEFT, x[0], f[6:0]};
        1: op = {OPC_ROT_RIGHT, x[0], f[6:0]};
        2: op = {OPC_SUB_LIT, x[8:0]};
        default: op = 14'h0000;
      endcase
      // short freeze while idle
      ce <= 1'b0;
      repeat (2) @(posedge pclk);
      ce <= 1'b1;
      run(op);
      model(op);
      check_all(f);
    end
    // second word while the first is still in its phases
    wr(OFS_INSTR, 32'h0);
    wr(OFS_INSTR, {18'h0, OPC_SUB_LIT, 9'h0FF});
    chk(er, 1'b1);
    rdr(OFS_STATE);
    chk(rd[0], 1'b0);
    rdr(OFS_WDOG);
    chk(rd[15:8] != 8'h00, 1'b1);
    run(OPC_HALT);
    rdr(OFS_STATE);
    chk(rd[1], 1'b1);
    chk(halted, 1'b1);
    rdr(OFS_STATUS);
    chk(rd[4:3], 2'b10);
    rdr(OFS_WDOG);
    chk(rd[15:8], 8'h00);
    chk(rd[7:0] < 8'h40, 1'b1);
    wr(OFS_INSTR, {18'h0, OPC_SUB_LIT, 9'h000});
    chk(er, 1'b1);
    rdr(OFS_ACC);
    chk(rd, acc);
    wr(OFS_CTRL, 32'h1);
    rdr(OFS_STATE);
    chk(rd[1], 1'b0);
    chk(halted, 1'b0);
    // literal equal to accumulator: zero, no borrow anywhere
    op = {OPC_SUB_LIT, 1'b1, acc[7:0]};
    run(op);
    sub_model(op[7:0]);
    rdr(OFS_STATUS);
    chk(rd[4:0], {2'b10, zr[0], dc[0], cy[0]});
    rdr(OFS_ACC);
    chk(rd, 32'h0);
    rdr(OFS_INSTR);
    chk(rd, {18'h0, op});
    stop_test();
  end
  // hang guard, far beyond the expected run length
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    stop_test();
  end
endmodule
